// file: dv/slfs_board_model.sv
/*
  Board side of the strap latch: strap resistors, power-good logic and the
  wire level of the three shared strap/clock pins.
  Assumes the bench sets the strap and power-good controls after a clock edge.
*/
`timescale 1ns/10ps

module slfs_board_model (
  input  wire logic [2:0] selCode,
  input  wire logic       testStrap,
  input  wire logic       dbgStrap,
  input  wire logic       lvdsStrap,
  input  wire logic       pgLow,
  input  wire logic       usbClockOut,
  input  wire logic       usbClockOeN,
  input  wire logic       freePciClockZero,
  input  wire logic       freePciClockZeroOeN,
  input  wire logic       freePciClockOne,
  input  wire logic       freePciClockOneOeN,
  output logic            powerGoodStrobe,
  output logic            freqSelBitA,
  output logic            freqSelBitB,
  output logic            freqSelBitC,
  output logic            testEntryStrap,
  output logic            debugClockStrap,
  output logic            lvdsRateStrap
);
  // Power-good logic pulls the strobe low to capture, high to ask power down
  assign powerGoodStrobe = ~pgLow;

  // Dedicated straps; B stays live because test mode reads it after capture
  assign freqSelBitB    = selCode[1];
  assign freqSelBitC    = selCode[2];
  assign testEntryStrap = testStrap;

  // Shared pins: the strap resistor wins only while the device floats the pin,
  // so once clocks run the inputs see clock edges, not the straps
  assign freqSelBitA     = usbClockOeN ? selCode[0] : usbClockOut;
  assign debugClockStrap = freePciClockZeroOeN ? dbgStrap : freePciClockZero;
  assign lvdsRateStrap   = freePciClockOneOeN ? lvdsStrap : freePciClockOne;
endmodule

// file: dv/slfs_strap_latch_tb_top.sv
/*
  Self-checking bench of the strap latch: every select code, pair roles,
  pin turnaround, power down, test mode and the register port.
  Assumes the design and slfs_board_model are compiled beforehand.
*/
`timescale 1ns/10ps
`include "slfs_defines.svh"

module slfs_strap_latch_tb_top
  import slfs_pkg::*;
;
  logic clk, sys_rst, powerGoodStrobe, freqSelBitA, freqSelBitB, freqSelBitC;
  logic testEntryStrap, debugClockStrap, lvdsRateStrap, usbClockOut, usbClockOeN;
  logic freePciClockZero, freePciClockZeroOeN, freePciClockOne, freePciClockOneOeN;
  logic hostFreqValid, pairAsHostClockTwo, lvdsRate100, powerDownRequest;
  logic testMode, outputsHiZ, strapsLatched, testStrap, dbgStrap, lvdsStrap, pgLow;
  logic [2:0] selCode;
  logic [8:0] hostFreqMhz;
  logic [31:0] busRdata, d;
  slfs_bus_req_t busReq;
  int errors, num_checks, c;
  logic [31:0] rates [5] = '{`SLFS_SRC_KHZ, `SLFS_PCI_KHZ, `SLFS_USB_KHZ,
                             `SLFS_DOT_KHZ, `SLFS_REF_KHZ};

  slfs_strap_latch i_slfs_strap_latch (.*);
  slfs_board_model i_slfs_board_model (.*);

  // Clock and time-zero values
  initial begin
    clk = 1'h0; sys_rst = 1'h1; busReq = '0; selCode = 3'h0;
    testStrap = 1'h0; dbgStrap = 1'h0; lvdsStrap = 1'h0; pgLow = 1'h0;
    errors = 0; num_checks = 0;
  end
  always #2 clk = ~clk;

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmp1(input logic got, input logic exp);
    cmp32({31'h0000_0000, got}, {31'h0000_0000, exp});
  endtask

  task automatic bus_write(input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    busReq <= '{addr: a, wdata: wd, wr: 1'h1, rd: 1'h0};
    @(posedge clk);
    busReq <= '0;
  endtask

  // Read data stands only in the cycle after the strobe, so sample it there
  task automatic bus_read(input logic [7:0] a, output logic [31:0] rv);
    @(posedge clk);
    busReq <= '{addr: a, wdata: 32'h0000_0000, wr: 1'h0, rd: 1'h1};
    @(posedge clk);
    busReq <= '0;
    #1 rv = busRdata;
  endtask

  // Power cycle, set straps, drop the strobe and let outputs settle
  task automatic restart(input logic [2:0] s, input logic t, input logic g, input logic l);
    @(posedge clk);
    sys_rst <= 1'h1;
    pgLow <= 1'h0;
    selCode <= s; testStrap <= t; dbgStrap <= g; lvdsStrap <= l;
    repeat (2) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    pgLow <= 1'h1;
    repeat (6) @(posedge clk);
    #1;
  endtask

  function automatic logic pin_level(input int w);
    case (w)
      0: return usbClockOut;
      1: return freePciClockZero;
      default: return freePciClockOne;
    endcase
  endfunction

  // Count level changes of one clock pin over n cycles
  task automatic count_edges(input int w, input int n, output int cnt);
    logic prev;
    cnt = 0;
    prev = pin_level(w);
    repeat (n) begin
      @(posedge clk);
      #1;
      if (pin_level(w) !== prev) cnt++;
      prev = pin_level(w);
    end
  endtask

  function automatic logic [8:0] exp_mhz(input logic [2:0] s);
    case (s)
      3'h5: return 9'h064;
      3'h1: return 9'h085;
      3'h3: return 9'h0A6;
      3'h2: return 9'h0C8;
      3'h0: return 9'h10A;
      3'h4: return 9'h14D;
      3'h6: return 9'h190;
      default: return 9'h000;
    endcase
  endfunction

  // A hang costs a mismatch; the tests need well under 5000 cycles
  initial begin
    repeat (20000) @(posedge clk);
    errors++;
    close_out();
  end

  // Main sequence
  initial begin
    logic [2:0] s;
    repeat (16) @(posedge clk);
    for (int k = 0; k < 8; k++) begin
      s = k[2:0];
      restart(s, 1'h0, s[0], s[1]);
      cmp1(strapsLatched, 1'h1);
      cmp32({23'h00_0000, hostFreqMhz}, {23'h00_0000, exp_mhz(s)});
      cmp1(hostFreqValid, s != 3'h7);
      cmp1(pairAsHostClockTwo, s[0]);
      cmp1(lvdsRate100, s[1]);
      cmp1(testMode, 1'h0);
      cmp1(usbClockOeN, 1'h0);
      bus_read(`SLFS_REG_STATUS, d);
      cmp32(d, {20'h0_0000, s != 3'h7, s, 4'h0, s[1], s[0], 1'h0, 1'h1});
      for (int r = 0; r < 5; r++) begin
        bus_read(`SLFS_REG_SRCKHZ + 8'(4 * r), d);
        cmp32(d, rates[r]);
      end
      // Straps moving after capture must change nothing
      @(posedge clk);
      selCode <= ~s; dbgStrap <= ~s[0]; lvdsStrap <= ~s[1];
      repeat (4) @(posedge clk);
      #1;
      cmp32({23'h00_0000, hostFreqMhz}, {23'h00_0000, exp_mhz(s)});
      cmp1(pairAsHostClockTwo, s[0]);
      cmp1(lvdsRate100, s[1]);
      count_edges(0, 24, c);
      cmp32(c, 32'h0000_0008);
      count_edges(2, 16, c);
      cmp32(c, 32'h0000_0004);
      // Strobe high after capture is a live power-down request
      @(posedge clk);
      pgLow <= 1'h0;
      repeat (3) @(posedge clk);
      #1;
      cmp1(powerDownRequest, 1'h1);
      count_edges(1, 16, c);
      cmp32(c, 32'h0000_0004);
      @(posedge clk);
      pgLow <= 1'h1;
      repeat (3) @(posedge clk);
      #1;
      cmp1(powerDownRequest, 1'h0);
    end
    // Test mode with select B high floats every shared pin
    restart(3'h2, 1'h1, 1'h0, 1'h0);
    cmp1(testMode, 1'h1);
    cmp1(outputsHiZ, 1'h1);
    cmp1(usbClockOeN & freePciClockZeroOeN & freePciClockOneOeN, 1'h1);
    @(posedge clk);
    selCode <= 3'h0;
    repeat (4) @(posedge clk);
    #1;
    cmp1(outputsHiZ, 1'h0);
    cmp1(usbClockOeN | freePciClockZeroOeN | freePciClockOneOeN, 1'h0);
    count_edges(1, 16, c);
    cmp32(c, 32'h0000_0008);
    count_edges(0, 16, c);
    cmp32(c, 32'h0000_0008);
    bus_read(`SLFS_REG_TESTDIV, d);
    cmp32(d, 32'h0000_0002);
    bus_write(`SLFS_REG_TESTDIV, 32'h0000_0004);
    repeat (8) @(posedge clk);
    count_edges(2, 16, c);
    cmp32(c, 32'h0000_0004);
    bus_write(`SLFS_REG_TESTDIV, 32'h0000_0000);
    bus_read(`SLFS_REG_TESTDIV, d);
    cmp32(d, 32'h0000_0001);
    bus_write(`SLFS_REG_HOSTMHZ, 32'h0000_FFFF);
    bus_read(`SLFS_REG_HOSTMHZ, d);
    cmp32(d, {23'h00_0000, exp_mhz(3'h2)});
    bus_read(8'h20, d);
    cmp32(d, 32'h0000_0000);
    close_out();
  end
endmodule

// file: logic/slfs_clk_div.sv
/*
  Divider that toggles a pin clock stand-in every halfCount cycles while run
  is high. Assumes halfCount is never zero; the top clamps it.
*/
`timescale 1ns/10ps
`include "slfs_defines.svh"

module slfs_clk_div
  import slfs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       run,
  input  wire logic [7:0] halfCount,
  output logic            clkLvl
);

  slfs_div_state_t s_q;
  slfs_div_state_t s_d;

  // Count to the half period, then flip the level; stopped means parked low
  always_comb begin
    s_d = s_q;
    if (!run) begin
      s_d.cnt = `SLFS_DIV_CNT_RST;
      s_d.lvl = 1'b0;
    end else if (s_q.cnt >= halfCount - 8'h01) begin
      s_d.cnt = `SLFS_DIV_CNT_RST;
      s_d.lvl = !s_q.lvl;
    end else begin
      s_d.cnt = s_q.cnt + 8'h01;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign clkLvl = s_q.lvl;

endmodule

// file: logic/slfs_defines.svh
/*
  Named constants of the strap latch and frequency select block: register
  offsets, status bit positions, reset values, decoded rates, divider counts.
  Assumes inclusion by the design files and the bench by bare name.
*/
`ifndef SLFS_DEFINES_SVH
`define SLFS_DEFINES_SVH

// Register offsets, byte addresses of aligned 32-bit words
`define SLFS_REG_STATUS   8'h00
`define SLFS_REG_HOSTMHZ  8'h04
`define SLFS_REG_TESTDIV  8'h08
`define SLFS_REG_SRCKHZ   8'h0C
`define SLFS_REG_PCIKHZ   8'h10
`define SLFS_REG_USBKHZ   8'h14
`define SLFS_REG_DOTKHZ   8'h18
`define SLFS_REG_REFKHZ   8'h1C

// Status register bit positions
`define SLFS_ST_LATCHED   0
`define SLFS_ST_TEST      1
`define SLFS_ST_HOSTPAIR  2
`define SLFS_ST_LVDS100   3
`define SLFS_ST_PWRDN     4
`define SLFS_ST_HIZ       5
`define SLFS_ST_SEL_LO    8
`define SLFS_ST_SEL_HI    10
`define SLFS_ST_VALID     11

// Reset values and limits
`define SLFS_TESTDIV_RST  8'h02
`define SLFS_TESTDIV_MIN  8'h01
`define SLFS_RDATA_RST    32'h0000_0000

// Fixed output rates in kHz, identical for every select code
`define SLFS_SRC_KHZ      32'h0001_86A0
`define SLFS_PCI_KHZ      32'h0000_8235
`define SLFS_USB_KHZ      32'h0000_BB80
`define SLFS_DOT_KHZ      32'h0001_7700
`define SLFS_REF_KHZ      32'h0000_37EE

// Select codes {C,B,A} and the decoded host rate in MHz
`define SLFS_SEL_100      3'h5
`define SLFS_SEL_133      3'h1
`define SLFS_SEL_166      3'h3
`define SLFS_SEL_200      3'h2
`define SLFS_SEL_266      3'h0
`define SLFS_SEL_333      3'h4
`define SLFS_SEL_400      3'h6
`define SLFS_SEL_RSVD     3'h7
`define SLFS_MHZ_100      9'h064
`define SLFS_MHZ_133      9'h085
`define SLFS_MHZ_166      9'h0A6
`define SLFS_MHZ_200      9'h0C8
`define SLFS_MHZ_266      9'h10A
`define SLFS_MHZ_333      9'h14D
`define SLFS_MHZ_400      9'h190
`define SLFS_MHZ_NONE     9'h000

// Half-period counts of the pin clock stand-ins, in system clock cycles
`define SLFS_PCI_HALF     8'h04
`define SLFS_USB_HALF     8'h03
`define SLFS_DIV_CNT_RST  8'h00

`endif

// file: logic/slfs_freq_decode.sv
/*
  Registered decoder from the latched select code to the host clock rate.
  Assumes the code is stable once latched; output lags it by one cycle.
*/
`timescale 1ns/10ps
`include "slfs_defines.svh"

module slfs_freq_decode
  import slfs_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       sys_rst,
  input  wire logic       enable,
  input  wire logic [2:0] selCode,
  output logic [8:0]      hostMhz,
  output logic            hostValid
);

  slfs_dec_state_t s_q;
  slfs_dec_state_t s_d;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Map every code; the reserved one gives no rate and no valid
  always_comb begin
    s_d = s_q;
    s_d.valid = enable;
    unique case (selCode)
      `SLFS_SEL_100:  s_d.mhz = `SLFS_MHZ_100;
      `SLFS_SEL_133:  s_d.mhz = `SLFS_MHZ_133;
      `SLFS_SEL_166:  s_d.mhz = `SLFS_MHZ_166;
      `SLFS_SEL_200:  s_d.mhz = `SLFS_MHZ_200;
      `SLFS_SEL_266:  s_d.mhz = `SLFS_MHZ_266;
      `SLFS_SEL_333:  s_d.mhz = `SLFS_MHZ_333;
      `SLFS_SEL_400:  s_d.mhz = `SLFS_MHZ_400;
      `SLFS_SEL_RSVD: begin
        s_d.mhz   = `SLFS_MHZ_NONE;
        s_d.valid = 1'b0;
      end
    endcase
    if (!enable) begin
      s_d.mhz = `SLFS_MHZ_NONE;
    end
  end

  // State register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign hostMhz   = s_q.mhz;
  assign hostValid = s_q.valid;

  a_decode_rates: assert property (
    (enable && selCode == `SLFS_SEL_266) |=> (hostMhz == `SLFS_MHZ_266 && hostValid))
    else $error("code 000 did not decode to 266 MHz");

  a_reserved_code: assert property (
    (selCode == `SLFS_SEL_RSVD) |=> (!hostValid && hostMhz == `SLFS_MHZ_NONE))
    else $error("reserved code produced a host rate");

endmodule

// file: logic/slfs_pkg.sv
/*
  Types of the strap latch and frequency select block.
  Assumes slfs_defines.svh beside it for every numeric constant.
*/
package slfs_pkg;

  // Capture phase, one-hot
  typedef enum logic [1:0] {
    SLFS_WAIT = 2'b01,
    SLFS_RUN  = 2'b10
  } slfs_phase_t;

  // Register port request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } slfs_bus_req_t;

  // Captured straps
  typedef struct packed {
    logic [2:0] sel;      // {C,B,A}
    logic       test;
    logic       hostPair;
    logic       lvds100;
  } slfs_straps_t;

  // Whole state of the top module
  typedef struct packed {
    slfs_phase_t  phase;
    logic         latched;
    slfs_straps_t straps;
    logic         pwrDn;
    logic         hiZ;
    logic [7:0]   testDiv;
    logic [31:0]  rdata;
    logic         usbOut;
    logic         usbOeN;
    logic         pci0Out;
    logic         pci0OeN;
    logic         pci1Out;
    logic         pci1OeN;
  } slfs_main_state_t;

  // State of a pin clock divider
  typedef struct packed {
    logic [7:0] cnt;
    logic       lvl;
  } slfs_div_state_t;

  // State of the host rate decoder
  typedef struct packed {
    logic [8:0] mhz;
    logic       valid;
  } slfs_dec_state_t;

endpackage

// file: logic/slfs_strap_latch.sv
/*
  Strap latch and frequency select logic of a multi-output clock generator:
  strap capture on the power-good strobe, decode of host rate and pair roles,
  test mode output control, shared pin turnaround and a small register port.
  Assumes straps are static around capture and all inputs are synchronous
  to clk; sys_rst stands for the power cycle.
  Clock pins are rate stand-ins divided down from clk, not true frequencies;
  software finds the true rates in the read-only rate registers.
*/
`timescale 1ns/10ps
`include "slfs_defines.svh"

module slfs_strap_latch
  import slfs_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          sys_rst,
  input  wire logic          powerGoodStrobe,
  input  wire logic          freqSelBitB,
  input  wire logic          freqSelBitC,
  input  wire logic          testEntryStrap,
  input  wire logic          freqSelBitA,
  output logic               usbClockOut,
  output logic               usbClockOeN,
  input  wire logic          debugClockStrap,
  output logic               freePciClockZero,
  output logic               freePciClockZeroOeN,
  input  wire logic          lvdsRateStrap,
  output logic               freePciClockOne,
  output logic               freePciClockOneOeN,
  input  wire slfs_bus_req_t busReq,
  output logic [31:0]        busRdata,
  output logic [8:0]         hostFreqMhz,
  output logic               hostFreqValid,
  output logic               pairAsHostClockTwo,
  output logic               lvdsRate100,
  output logic               powerDownRequest,
  output logic               testMode,
  output logic               outputsHiZ,
  output logic               strapsLatched
);

  slfs_main_state_t s_q;
  slfs_main_state_t s_d;

  // Divider levels and decoder results that feed the next state
  logic       pciLvl;
  logic       usbLvl;
  logic       refLvl;
  logic       testOn;
  logic       usbRun;
  logic [8:0] decMhz;
  logic       decValid;

  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // Free PCI stand-in runs from reset and ignores power-down
  slfs_clk_div u_pci_div (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .run       (1'b1),
    .halfCount (`SLFS_PCI_HALF),
    .clkLvl    (pciLvl)
  );

  // USB stand-in stops in power-down
  slfs_clk_div u_usb_div (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .run       (usbRun),
    .halfCount (`SLFS_USB_HALF),
    .clkLvl    (usbLvl)
  );

  // Reference divided by N, only alive in test mode
  slfs_clk_div u_ref_div (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .run       (testOn),
    .halfCount (s_q.testDiv),
    .clkLvl    (refLvl)
  );

  // Host rate from the held select code
  slfs_freq_decode u_decode (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .enable    (s_q.latched),
    .selCode   (s_q.straps.sel),
    .hostMhz   (decMhz),
    .hostValid (decValid)
  );

  assign testOn = s_q.latched && s_q.straps.test;
  assign usbRun = s_q.latched && !s_q.pwrDn;

  // Next state: capture, power-down, pin drive, register port
  always_comb begin
    s_d = s_q;

    // Capture fires once; after that the straps are frozen
    unique case (s_q.phase)
      SLFS_WAIT: begin
        if (!powerGoodStrobe) begin
          s_d.phase           = SLFS_RUN;
          s_d.latched         = 1'b1;
          s_d.straps.sel      = {freqSelBitC, freqSelBitB, freqSelBitA};
          s_d.straps.test     = testEntryStrap;
          s_d.straps.hostPair = debugClockStrap;
          s_d.straps.lvds100  = lvdsRateStrap;
        end
      end
      SLFS_RUN: begin
        s_d.straps = s_q.straps;
      end
    endcase

    // Strobe pin reused as a live power-down once captured
    // The capture cycle never counts: latched is still low while it happens
    s_d.pwrDn = s_q.latched && powerGoodStrobe;

    // Test mode: select-B read live picks float or ref/N
    // B is never frozen, so the float choice may move while in test mode
    s_d.hiZ = testOn && freqSelBitB;

    // Shared pins stay released until capture so the straps can be read
    // Enables follow the next float value so pin and flag turn in one cycle
    s_d.usbOeN  = !s_q.latched || s_d.hiZ;
    s_d.pci0OeN = !s_q.latched || s_d.hiZ;
    s_d.pci1OeN = !s_q.latched || s_d.hiZ;
    if (testOn) begin
      s_d.usbOut  = refLvl;
      s_d.pci0Out = refLvl;
      s_d.pci1Out = refLvl;
    end else begin
      s_d.usbOut  = usbLvl;
      s_d.pci0Out = pciLvl;
      s_d.pci1Out = pciLvl;
    end

    // Write: only the test divider is writable; zero would give a 256-cycle half period
    // Writes to read-only addresses are dropped without any error indication
    if (busReq.wr && busReq.addr == `SLFS_REG_TESTDIV) begin
      if (busReq.wdata[7:0] == 8'h00) begin
        s_d.testDiv = `SLFS_TESTDIV_MIN;
      end else begin
        s_d.testDiv = busReq.wdata[7:0];
      end
    end

    // Read data stand for one cycle only; unmapped reads return zero
    s_d.rdata = `SLFS_RDATA_RST;
    if (busReq.rd) begin
      case (busReq.addr)
        `SLFS_REG_STATUS: begin
          s_d.rdata[`SLFS_ST_LATCHED]  = s_q.latched;
          s_d.rdata[`SLFS_ST_TEST]     = testOn;
          s_d.rdata[`SLFS_ST_HOSTPAIR] = s_q.straps.hostPair;
          s_d.rdata[`SLFS_ST_LVDS100]  = s_q.straps.lvds100;
          s_d.rdata[`SLFS_ST_PWRDN]    = s_q.pwrDn;
          s_d.rdata[`SLFS_ST_HIZ]      = s_q.hiZ;
          s_d.rdata[`SLFS_ST_SEL_HI:`SLFS_ST_SEL_LO] = s_q.straps.sel;
          s_d.rdata[`SLFS_ST_VALID]    = decValid;
        end
        `SLFS_REG_HOSTMHZ: s_d.rdata[8:0] = decMhz;
        `SLFS_REG_TESTDIV: s_d.rdata[7:0] = s_q.testDiv;
        `SLFS_REG_SRCKHZ:  s_d.rdata = `SLFS_SRC_KHZ;
        `SLFS_REG_PCIKHZ:  s_d.rdata = `SLFS_PCI_KHZ;
        `SLFS_REG_USBKHZ:  s_d.rdata = `SLFS_USB_KHZ;
        `SLFS_REG_DOTKHZ:  s_d.rdata = `SLFS_DOT_KHZ;
        `SLFS_REG_REFKHZ:  s_d.rdata = `SLFS_REF_KHZ;
        default:           s_d.rdata = `SLFS_RDATA_RST;
      endcase
    end
  end

  // State register; pins come up released and undriven
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_q         <= '0;
      s_q.phase   <= SLFS_WAIT;
      s_q.testDiv <= `SLFS_TESTDIV_RST;
      s_q.usbOeN  <= 1'b1;
      s_q.pci0OeN <= 1'b1;
      s_q.pci1OeN <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from flops
  assign usbClockOut         = s_q.usbOut;
  assign usbClockOeN         = s_q.usbOeN;
  assign freePciClockZero    = s_q.pci0Out;
  assign freePciClockZeroOeN = s_q.pci0OeN;
  assign freePciClockOne     = s_q.pci1Out;
  assign freePciClockOneOeN  = s_q.pci1OeN;
  assign busRdata            = s_q.rdata;
  assign hostFreqMhz         = decMhz;
  assign hostFreqValid       = decValid;
  assign pairAsHostClockTwo  = s_q.straps.hostPair;
  assign lvdsRate100         = s_q.straps.lvds100;
  assign powerDownRequest    = s_q.pwrDn;
  assign testMode            = s_q.straps.test;
  assign outputsHiZ          = s_q.hiZ;
  assign strapsLatched       = s_q.latched;

  // Rate registers and capture checks, all on the default clocking
  a_pci_rate_read: assert property (
    (busReq.rd && busReq.addr == `SLFS_REG_PCIKHZ) |=> (busRdata == `SLFS_PCI_KHZ))
    else $error("PCI rate register read wrong value");

  a_capture_on_strobe: assert property (
    (!strapsLatched && !powerGoodStrobe) |=>
      (strapsLatched && hostFreqMhz == `SLFS_MHZ_NONE) ##1 hostFreqValid == ($past(s_q.straps.sel, 1) != `SLFS_SEL_RSVD))
    else $error("strobe low did not capture straps");

  a_power_down_live: assert property (
    strapsLatched |=> (powerDownRequest == $past(powerGoodStrobe)))
    else $error("power-down does not follow strobe pin");

  a_lvds_sample: assert property (
    (!strapsLatched && !powerGoodStrobe) |=> (lvdsRate100 == $past(lvdsRateStrap)))
    else $error("LVDS rate strap not sampled at capture");

  a_debug_host_pair: assert property (
    (!strapsLatched && !powerGoodStrobe && debugClockStrap) |=> pairAsHostClockTwo)
    else $error("debug strap high did not select host pair two");

  a_debug_serial_pair: assert property (
    (!strapsLatched && !powerGoodStrobe && !debugClockStrap) |=> !pairAsHostClockTwo)
    else $error("debug strap low did not select serial pair seven");

  a_free_pci_runs: assert property (
    (strapsLatched && !testMode) |-> ##[1:12] $changed(freePciClockZero))
    else $error("free PCI clock stopped toggling");

  a_usb_pin_turn: assert property (
    (!strapsLatched |-> usbClockOeN) and
    (strapsLatched |=> (usbClockOeN == outputsHiZ)))
    else $error("USB pin drive does not follow capture");

  a_test_float: assert property (
    (strapsLatched && testMode && freqSelBitB) |=>
      (outputsHiZ && usbClockOeN && freePciClockZeroOeN && freePciClockOneOeN))
    else $error("test float did not release outputs");

  a_test_entry: assert property (
    (!strapsLatched && !powerGoodStrobe) |=> (testMode == $past(testEntryStrap)))
    else $error("test strap not sampled at capture");

  a_straps_hold: assert property (
    strapsLatched |=> (strapsLatched && $stable(pairAsHostClockTwo) &&
      $stable(lvdsRate100) && $stable(testMode)))
    else $error("captured straps changed after capture");

  // Shared pins stay released for the straps and turn with the float flag
  a_pins_released: assert property (
    !strapsLatched |-> (freePciClockZeroOeN && freePciClockOneOeN))
    else $error("PCI pins driven before strap capture");

  a_pci_pins_turn: assert property (
    strapsLatched |=> (freePciClockZeroOeN == outputsHiZ &&
      freePciClockOneOeN == outputsHiZ))
    else $error("PCI pin drive does not follow capture");

  a_pci_runs_pwrdn: assert property (
    (strapsLatched && !testMode && powerDownRequest) |-> ##[1:12] $changed(freePciClockOne))
    else $error("free PCI clock gated by power-down");

  // Power-down only exists after capture and parks the USB clock low outside test mode
  a_pwrdn_needs_latch: assert property (
    powerDownRequest |-> strapsLatched)
    else $error("power-down raised before strap capture");

  a_pwrdn_clears: assert property (
    (strapsLatched && !powerGoodStrobe) |=> !powerDownRequest)
    else $error("power-down held with strobe pin low");

  a_pwrdn_stops_usb: assert property (
    (strapsLatched && !testMode && powerDownRequest) [*3] |-> !usbClockOut)
    else $error("USB clock still running in power-down");

  // Test mode: float needs test, ref/N reaches all three pins and keeps moving
  a_float_needs_test: assert property (
    outputsHiZ |-> (strapsLatched && testMode))
    else $error("outputs floated outside test mode");

  a_ref_all_pins: assert property (
    (strapsLatched && testMode) |=> (usbClockOut == freePciClockZero &&
      usbClockOut == freePciClockOne))
    else $error("ref/N missing on a shared pin");

  a_ref_div_runs: assert property (
    (strapsLatched && testMode) |-> ##[1:300] $changed(usbClockOut))
    else $error("ref/N clock stopped in test mode");

  a_div_zero_write: assert property (
    (busReq.wr && busReq.addr == `SLFS_REG_TESTDIV && busReq.wdata[7:0] == 8'h00) |=>
      (s_q.testDiv == `SLFS_TESTDIV_MIN))
    else $error("zero divider write not clamped");

  // Register port: status and host rate read back what the pins show
  a_status_latched: assert property (
    (busReq.rd && busReq.addr == `SLFS_REG_STATUS) |=>
      (busRdata[`SLFS_ST_LATCHED] == $past(strapsLatched) &&
       busRdata[`SLFS_ST_VALID] == $past(hostFreqValid)))
    else $error("status read disagrees with capture state");

  a_host_rate_read: assert property (
    (busReq.rd && busReq.addr == `SLFS_REG_HOSTMHZ) |=> (busRdata[8:0] == $past(hostFreqMhz)))
    else $error("host rate register read wrong value");

  // Decoded results exist only after capture and then stay put
  a_valid_needs_latch: assert property (
    hostFreqValid |-> (strapsLatched && hostFreqMhz != `SLFS_MHZ_NONE))
    else $error("host rate valid without capture");

  a_host_rate_hold: assert property (
    (strapsLatched ##1 strapsLatched) |=> ($stable(hostFreqMhz) && $stable(hostFreqValid)))
    else $error("host rate moved after capture");

  a_pair_needs_latch: assert property (
    pairAsHostClockTwo |-> strapsLatched)
    else $error("pair role set without capture");

  a_lvds_needs_latch: assert property (
    lvdsRate100 |-> strapsLatched)
    else $error("LVDS rate set without capture");

  a_test_needs_latch: assert property (
    testMode |-> strapsLatched)
    else $error("test mode set without capture");

endmodule
